// ### acs_scan_ctrl.sv
// eight-channel converter scan control with apb registers and axis feedback
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`include "acs_defines.svh"
module acs_scan_ctrl #(
   parameter int SETTLE_CYC = `ACS_SETTLE_CYC,
   parameter int SERVO_CYC  = `ACS_SERVO_CYC
) (
   input  wire logic        I_MCLK,
   input  wire logic        I_RSTN,
   input  wire logic        I_CE,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   output logic      [2:0]  O_ADC_SEL,
   output logic      [1:0]  O_ADC_RANGE,
   output logic             O_ADC_START,
   input  wire logic        I_ADC_DONE,
   input  wire logic [11:0] I_ADC_DATA,
   output logic      [63:0] O_AXIS_POS,
   output logic      [3:0]  O_AXIS_UPD,
   output logic      [3:0]  O_AXIS_STALE
);
   import acs_pkg::*;

   acs_state_s s;
   acs_state_s next_s;

   logic [2:0]  pick_from;
   logic [2:0]  pick_next;
   logic        pick_any;
   logic [15:0] conv_val;
   logic        acc;
   logic        done_edge;
   logic        hit;
   logic        is_res;
   logic [2:0]  res_idx;
   logic [31:0] rd_data;
   logic [1:0]  cur_use;

   // from idle the search starts above the top channel, giving the lowest enabled
   assign pick_from = (s.state == ACS_IDLE) ? 3'h7 : s.cur;

   acs_chan_pick u_pick (
      .i_cur  (pick_from),
      .i_mask (s.chen),
      .o_next (pick_next),
      .o_any  (pick_any)
   );

   acs_code_fmt u_fmt (
      .i_code  (I_ADC_DATA),
      .i_range (s.adc_range),
      .o_value (conv_val)
   );

   assign acc     = I_PSEL && I_PENABLE;
   assign is_res  = (I_PADDR[7:5] == `ACS_RES_PAGE);
   assign res_idx = I_PADDR[4:2];
   assign hit     = (I_PADDR[1:0] == 2'h0) && (is_res ||
                    I_PADDR == `ACS_OFF_CTRL || I_PADDR == `ACS_OFF_CHEN ||
                    I_PADDR == `ACS_OFF_RANGE || I_PADDR == `ACS_OFF_USE ||
                    I_PADDR == `ACS_OFF_MAP || I_PADDR == `ACS_OFF_STAT ||
                    I_PADDR == `ACS_OFF_SCANS);
   assign done_edge = (s.state == ACS_CONV) && I_ADC_DONE;
   // use field of the channel being converted, bit-selected by name below
   assign cur_use   = acs_fld2(s.chuse, s.cur);

   always_comb begin
      rd_data = 32'h0000_0000;
      if (is_res) begin
         rd_data = {{16{s.result[res_idx][15]}}, s.result[res_idx]};
      end else begin
         unique case (I_PADDR)
            `ACS_OFF_CTRL:  rd_data[`ACS_CTRL_RUN] = s.run;
            `ACS_OFF_CHEN:  rd_data[7:0] = s.chen;
            `ACS_OFF_RANGE: rd_data[15:0] = s.range;
            `ACS_OFF_USE:   rd_data[15:0] = s.chuse;
            `ACS_OFF_MAP:   rd_data[11:0] = s.map;
            `ACS_OFF_STAT: begin
               rd_data[`ACS_STAT_BUSY] = (s.state != ACS_IDLE);
               rd_data[`ACS_STAT_CUR +: 3] = s.cur;
               rd_data[`ACS_STAT_STALE +: 4] = s.stale;
               rd_data[`ACS_STAT_FRESH +: 8] = s.fresh;
            end
            `ACS_OFF_SCANS: rd_data[15:0] = s.scans;
            default:        rd_data = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      next_s = s;
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      next_s.adc_start = 1'b0;
      next_s.axis_upd = 4'h0;

      // apb: answer one cycle into the access phase
      if (acc && !s.pready) begin
         next_s.pready = 1'b1;
         next_s.pslverr = !hit;
         next_s.prdata = hit ? rd_data : 32'h0000_0000;
      end
      if (acc && s.pready && hit) begin
         if (I_PWRITE) begin
            unique case (I_PADDR)
               `ACS_OFF_CTRL:  next_s.run = I_PWDATA[`ACS_CTRL_RUN];
               `ACS_OFF_CHEN:  next_s.chen = I_PWDATA[7:0];
               `ACS_OFF_RANGE: next_s.range = I_PWDATA[15:0];
               `ACS_OFF_USE:   next_s.chuse = I_PWDATA[15:0];
               `ACS_OFF_MAP:   next_s.map = I_PWDATA[11:0];
               default:        next_s.run = s.run;
            endcase
         end else if (is_res) begin
            next_s.fresh[res_idx] = 1'b0;
         end
      end

      // feedback age, flagged stale once a servo period passes without a refresh
      for (int a = 0; a < `ACS_AXES; a++) begin
         if (s.age[a] == 12'(SERVO_CYC - 1)) begin
            next_s.stale[a] = 1'b1;
         end else begin
            next_s.age[a] = s.age[a] + 12'h001;
         end
      end

      unique case (s.state)
         ACS_IDLE: begin
            if (s.run && pick_any) begin
               next_s.cur = pick_next;
               next_s.adc_range = acs_fld2(s.range, pick_next);
               next_s.settle_cnt = 8'(SETTLE_CYC);
               next_s.state = ACS_SETTLE;
            end
         end
         ACS_SETTLE: begin
            if (s.settle_cnt == 8'h00) begin
               next_s.adc_start = 1'b1;
               next_s.state = ACS_CONV;
            end else begin
               next_s.settle_cnt = s.settle_cnt - 8'h01;
            end
         end
         ACS_CONV: begin
            if (I_ADC_DONE) begin
               if (cur_use[`ACS_USE_RB]) begin
                  next_s.result[s.cur] = conv_val;
                  next_s.fresh[s.cur] = 1'b1;
               end
               if (cur_use[`ACS_USE_FB]) begin
                  for (int a = 0; a < `ACS_AXES; a++) begin
                     if (acs_fld3(s.map, 2'(a)) == s.cur) begin
                        next_s.axis_pos[a] = conv_val;
                        next_s.axis_upd[a] = 1'b1;
                        next_s.age[a] = 12'h000;
                        next_s.stale[a] = 1'b0;
                     end
                  end
               end
               if (pick_next <= s.cur) begin
                  next_s.scans = s.scans + 16'h0001;
               end
               if (s.run && pick_any) begin
                  next_s.cur = pick_next;
                  next_s.adc_range = acs_fld2(s.range, pick_next);
                  next_s.settle_cnt = 8'(SETTLE_CYC);
                  next_s.state = ACS_SETTLE;
               end else begin
                  next_s.state = ACS_IDLE;
               end
            end
         end
         default: next_s.state = ACS_IDLE;
      endcase
   end

   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         s <= '0;
         s.state <= ACS_IDLE;
         s.chen <= `ACS_RST_CHEN;
         s.range <= `ACS_RST_RANGE;
         s.chuse <= `ACS_RST_USE;
         s.map <= `ACS_RST_MAP;
      end else if (I_CE) begin
         s <= next_s;
      end
   end

   assign O_PRDATA = s.prdata;
   assign O_PREADY = s.pready;
   assign O_PSLVERR = s.pslverr;
   assign O_ADC_SEL = s.cur;
   assign O_ADC_RANGE = s.adc_range;
   assign O_ADC_START = s.adc_start;
   assign O_AXIS_POS = s.axis_pos;
   assign O_AXIS_UPD = s.axis_upd;
   assign O_AXIS_STALE = s.stale;

   // enabled channels above the current one, for the ascending-order check
   logic [7:0] above_mask;
   assign above_mask = s.chen & (8'hFE << s.cur);

   chk_start_after_settle: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && s.state == ACS_SETTLE && s.settle_cnt == 8'h00
      |=> O_ADC_START && s.state == ACS_CONV
   ) else $error("converter start did not follow settling");

   chk_start_enabled: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && s.state == ACS_IDLE && next_s.state == ACS_SETTLE
      |=> s.chen[O_ADC_SEL]
   ) else $error("scan selected a disabled channel");

   chk_scan_ascends: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && done_edge && s.run && |s.chen && !(acc && s.pready)
      |=> (O_ADC_SEL > $past(s.cur)) == $past(|above_mask) && s.chen[O_ADC_SEL]
   ) else $error("scan order not ascending with wrap");

   chk_bipolar_sign: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && done_edge && acs_bipolar(s.adc_range) && cur_use[`ACS_USE_RB]
      |=> s.result[$past(s.cur)][15:11] == {5{~$past(I_ADC_DATA[11])}}
   ) else $error("bipolar result sign wrong");

   chk_unipolar_span: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && done_edge && !acs_bipolar(s.adc_range) && cur_use[`ACS_USE_RB]
      |=> s.result[$past(s.cur)] == {4'h0, $past(I_ADC_DATA)}
   ) else $error("unipolar result not stored as is");

   chk_fb_only_keeps: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && done_edge && !cur_use[`ACS_USE_RB]
      |=> s.result[$past(s.cur)] == $past(s.result[s.cur])
   ) else $error("feedback-only channel overwrote readback");

   chk_axis_feed: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && done_edge && cur_use[`ACS_USE_FB] && s.map[2:0] == s.cur
      |=> O_AXIS_UPD[0] && O_AXIS_POS[15:0] == $past(conv_val) && !O_AXIS_STALE[0]
   ) else $error("mapped axis did not receive feedback");

   chk_stale_deadline: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && s.age[0] == 12'(SERVO_CYC - 1) && !next_s.axis_upd[0]
      |=> O_AXIS_STALE[0]
   ) else $error("stale flag missed servo deadline");

   chk_pready_pulse: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && O_PREADY |=> !O_PREADY
   ) else $error("pready held for more than one cycle");

   chk_unaligned_err: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && acc && !s.pready && I_PADDR[1:0] != 2'h0
      |=> O_PREADY && O_PSLVERR
   ) else $error("unaligned access not refused");

   chk_range_latch: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && s.state == ACS_IDLE && next_s.state == ACS_SETTLE
      |=> O_ADC_RANGE == acs_fld2($past(s.range), O_ADC_SEL)
   ) else $error("range not latched at channel selection");

   chk_range_write: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && acc && s.pready && I_PWRITE && I_PADDR == `ACS_OFF_RANGE
      |=> s.range == $past(I_PWDATA[15:0])
   ) else $error("range register write lost");

   chk_chen_write: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && acc && s.pready && I_PWRITE && I_PADDR == `ACS_OFF_CHEN
      |=> s.chen == $past(I_PWDATA[7:0])
   ) else $error("channel enable write lost");

   chk_use_write: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && acc && s.pready && I_PWRITE && I_PADDR == `ACS_OFF_USE
      |=> s.chuse == $past(I_PWDATA[15:0])
   ) else $error("channel use write lost");

   chk_map_write: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && acc && s.pready && I_PWRITE && I_PADDR == `ACS_OFF_MAP
      |=> s.map == $past(I_PWDATA[11:0])
   ) else $error("axis map write lost");

   chk_sel_stable: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && s.state != ACS_IDLE && !done_edge
      |=> $stable(O_ADC_SEL) && $stable(O_ADC_RANGE)
   ) else $error("mux select moved during a conversion");

   chk_start_pulse: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && O_ADC_START |=> !O_ADC_START
   ) else $error("converter start held for more than one cycle");

   chk_settle_load: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && s.state == ACS_IDLE && next_s.state == ACS_SETTLE
      |=> s.settle_cnt == 8'(SETTLE_CYC)
   ) else $error("settling count not loaded");

   chk_rb_only_axis: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && done_edge && !cur_use[`ACS_USE_FB]
      |=> O_AXIS_UPD == 4'h0
   ) else $error("non-feedback channel updated an axis");

   chk_result_fresh: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE && done_edge && cur_use[`ACS_USE_RB]
      |=> s.fresh[$past(s.cur)]
   ) else $error("stored result not flagged fresh");

   chk_stale_clear: assert property (
      @(posedge I_MCLK) disable iff (!I_RSTN)
      I_CE |-> (O_AXIS_UPD & O_AXIS_STALE) == 4'h0
   ) else $error("axis stale while being updated");

endmodule

// ### acs_defines.svh
// register map, field positions, reset values and timing constants of the channel scanner
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

`define ACS_CHANS        8
`define ACS_AXES         4
`define ACS_CODE_W       12
`define ACS_VAL_W        16
`define ACS_AGE_W        12
`define ACS_SETTLE_W     8

`define ACS_OFF_CTRL     8'h00
`define ACS_OFF_CHEN     8'h04
`define ACS_OFF_RANGE    8'h08
`define ACS_OFF_USE      8'h0C
`define ACS_OFF_MAP      8'h10
`define ACS_OFF_STAT     8'h14
`define ACS_OFF_SCANS    8'h18
`define ACS_RES_PAGE     3'h1

`define ACS_CTRL_RUN     0
`define ACS_STAT_BUSY    0
`define ACS_STAT_CUR     1
`define ACS_STAT_STALE   4
`define ACS_STAT_FRESH   8

`define ACS_RST_CHEN     8'h00
`define ACS_RST_RANGE    16'h0000
`define ACS_RST_USE      16'hAAAA
`define ACS_RST_MAP      12'h688

`define ACS_RANGE_BI10   2'h0
`define ACS_RANGE_BI5    2'h1
`define ACS_RANGE_UNI10  2'h2
`define ACS_RANGE_UNI5   2'h3
`define ACS_USE_FB       0
`define ACS_USE_RB       1
`define ACS_CODE_MSB     11

`define ACS_CLK_NS       20
`define ACS_SETTLE_NS    200
`define ACS_SERVO_NS     62500
`define ACS_SETTLE_CYC   ((`ACS_SETTLE_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_SERVO_CYC    (`ACS_SERVO_NS / `ACS_CLK_NS)

`endif

// ### acs_pkg.sv
// types and shared decode functions of the channel scanner
package acs_pkg;
`include "acs_defines.svh"

   typedef enum logic [2:0] {
      ACS_IDLE   = 3'b001,
      ACS_SETTLE = 3'b010,
      ACS_CONV   = 3'b100
   } acs_state_e;

   typedef logic [`ACS_VAL_W-1:0] acs_val_t;

   typedef struct packed {
      acs_state_e                                  state;
      logic [2:0]                                  cur;
      logic [1:0]                                  adc_range;
      logic                                        adc_start;
      logic [`ACS_SETTLE_W-1:0]                    settle_cnt;
      logic                                        run;
      logic [`ACS_CHANS-1:0]                       chen;
      logic [2*`ACS_CHANS-1:0]                     range;
      logic [2*`ACS_CHANS-1:0]                     chuse;
      logic [3*`ACS_AXES-1:0]                      map;
      logic [`ACS_CHANS-1:0][`ACS_VAL_W-1:0]       result;
      logic [`ACS_CHANS-1:0]                       fresh;
      logic [`ACS_AXES-1:0][`ACS_VAL_W-1:0]        axis_pos;
      logic [`ACS_AXES-1:0]                        axis_upd;
      logic [`ACS_AXES-1:0][`ACS_AGE_W-1:0]        age;
      logic [`ACS_AXES-1:0]                        stale;
      logic [15:0]                                 scans;
      logic                                        pready;
      logic                                        pslverr;
      logic [31:0]                                 prdata;
   } acs_state_s;

   function automatic logic [1:0] acs_fld2(input logic [15:0] v, input logic [2:0] i);
      acs_fld2 = v[{i, 1'b0} +: 2];
   endfunction

   function automatic logic [2:0] acs_fld3(input logic [11:0] v, input logic [1:0] i);
      acs_fld3 = v[3*i +: 3];
   endfunction

   function automatic logic acs_bipolar(input logic [1:0] r);
      acs_bipolar = (r == `ACS_RANGE_BI10) || (r == `ACS_RANGE_BI5);
   endfunction

endpackage

// ### acs_chan_pick.sv
// finds the next enabled channel above the given one, wrapping to the lowest
`timescale 1ns/1ns
module acs_chan_pick (
   input  wire logic [2:0] i_cur,
   input  wire logic [7:0] i_mask,
   output logic      [2:0] o_next,
   output logic            o_any
);
   import acs_pkg::*;

   always_comb begin
      logic [2:0] c;
      c = i_cur;
      o_next = i_cur;
      // walk down so the nearest channel above wins
      for (int k = 8; k >= 1; k--) begin
         c = i_cur + 3'(k);
         if (i_mask[c]) begin
            o_next = c;
         end
      end
      o_any = |i_mask;
   end
endmodule

// ### acs_code_fmt.sv
// turns a raw converter code into the signed or unsigned result for its range
`timescale 1ns/1ns
`include "acs_defines.svh"
module acs_code_fmt (
   input  wire logic [11:0] i_code,
   input  wire logic [1:0]  i_range,
   output logic      [15:0] o_value
);
   import acs_pkg::*;

   always_comb begin
      if (acs_bipolar(i_range)) begin
         // offset binary to two's complement, -2048..2047
         o_value = {{4{~i_code[`ACS_CODE_MSB]}}, ~i_code[`ACS_CODE_MSB], i_code[10:0]};
      end else begin
         o_value = {4'h0, i_code};
      end
   end
endmodule

// ### acs_adc_model.sv
// behavioural model of the multiplexed converter seen by the scan control
`timescale 1ns/1ns
module acs_adc_model (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_start,
   input  wire logic [2:0]  i_sel,
   input  wire logic [95:0] i_codes,
   input  wire logic [3:0]  i_delay,
   output logic             o_done,
   output logic      [11:0] o_data
);
   logic       busy;
   logic [3:0] cnt;
   logic [2:0] ch;

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy   <= 1'b0;
         cnt    <= 4'h0;
         ch     <= 3'h0;
         o_done <= 1'b0;
         o_data <= 12'h000;
      end else begin
         o_done <= 1'b0;
         // data is only valid with done; otherwise it keeps toggling
         o_data <= ~o_data;
         if (i_start) begin
            busy <= 1'b1;
            cnt  <= i_delay;
            ch   <= i_sel;
         end else if (busy) begin
            if (cnt == 4'h0) begin
               busy   <= 1'b0;
               o_done <= 1'b1;
               o_data <= i_codes[12*ch +: 12];
            end else begin
               cnt <= cnt - 4'h1;
            end
         end
      end
   end
endmodule

// ### tb.sv
// testbench of the channel scanner: registers, result format, scan order, feedback
`timescale 1ns/1ns
module tb;
   typedef struct packed {
      logic [2:0]  ch;
      logic [1:0]  rng;
      logic [11:0] code;
      logic [31:0] exp;
   } acs_row_s;
   logic        clk, rstn, ce, psel, pen, pwr, pready, pslverr, start, done, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  sel;
   logic [1:0]  rng, last_rng;
   logic [11:0] data;
   logic [63:0] pos;
   logic [3:0]  upd, stale, delay;
   logic [95:0] codes;
   logic [2:0]  selq[$];
   logic [2:0]  ord[3];
   acs_row_s    rows[6];
   int          failures, comparisons, i;

   acs_scan_ctrl #(.SETTLE_CYC(3), .SERVO_CYC(40)) u_dut (
      .I_MCLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .O_ADC_SEL(sel), .O_ADC_RANGE(rng),
      .O_ADC_START(start), .I_ADC_DONE(done), .I_ADC_DATA(data), .O_AXIS_POS(pos),
      .O_AXIS_UPD(upd), .O_AXIS_STALE(stale));

   acs_adc_model u_adc (
      .i_clk(clk), .i_rstn(rstn), .i_start(start), .i_sel(sel), .i_codes(codes),
      .i_delay(delay), .o_done(done), .o_data(data));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      if (n >= 50) failures++;
      rd  = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask

   task automatic wait_fresh(input int n);
      int k;
      k = 0;
      apb(1'b0, 8'h14, 32'h0);
      while (rd[8+n] !== 1'b1 && k < 40) begin
         k++;
         apb(1'b0, 8'h14, 32'h0);
      end
      if (k >= 40) failures++;
   endtask

   task automatic final_report;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      if (start === 1'b1) begin
         selq.push_back(sel);
         last_rng = rng;
      end
   end

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      #400000;
      failures++;
      final_report;
   end

   initial begin
      rstn = 1'b0; ce = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; delay = 4'h0; codes = 96'h0; failures = 0; comparisons = 0;
      ord = '{3'h1, 3'h3, 3'h6};
      rows[0] = '{3'h0, 2'h0, 12'h000, 32'hFFFFF800};
      rows[1] = '{3'h1, 2'h1, 12'hFFF, 32'h000007FF};
      rows[2] = '{3'h2, 2'h2, 12'hFFF, 32'h00000FFF};
      rows[3] = '{3'h3, 2'h3, 12'h001, 32'h00000001};
      rows[4] = '{3'h4, 2'h0, 12'h7FF, 32'hFFFFFFFF};
      rows[5] = '{3'h7, 2'h3, 12'h123, 32'h00000123};
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b1, 8'h0C, 32'h0000FFFF);
      for (i = 0; i < 6; i++) begin
         codes[12*rows[i].ch +: 12] <= rows[i].code;
         apb(1'b1, 8'h08, 32'(rows[i].rng) << (2*rows[i].ch));
         apb(1'b1, 8'h04, 32'h1 << rows[i].ch);
         apb(1'b1, 8'h00, 32'h1);
         wait_fresh(rows[i].ch);
         apb(1'b0, 8'h20 + {3'h0, rows[i].ch, 2'h0}, 32'h0);
         chk("result", rd, rows[i].exp);
         chk("adc range", {30'h0, last_rng}, {30'h0, rows[i].rng});
         if (rows[i].ch < 4)
            chk("axis pos", {16'h0, pos[16*rows[i].ch +: 16]}, {16'h0, rows[i].exp[15:0]});
      end
      $display("test ranges done");
      rstn <= 1'b0;
      repeat (5) @(posedge clk);
      chk("reset outputs", {21'h0, pready, pslverr, start, upd, stale}, 32'h0);
      chk("reset sel", {27'h0, sel, rng}, 32'h0);
      chk("reset prdata", prdata, 32'h0);
      rstn <= 1'b1;
      apb(1'b0, 8'h04, 32'h0); chk("chen reset", rd, 32'h0);
      apb(1'b0, 8'h0C, 32'h0); chk("use reset", rd, 32'h0000AAAA);
      apb(1'b0, 8'h10, 32'h0); chk("map reset", rd, 32'h00000688);
      apb(1'b0, 8'h1C, 32'h0); chk("unmapped err", {31'h0, err}, 32'h1);
      apb(1'b1, 8'h06, 32'hFF); chk("unaligned err", {31'h0, err}, 32'h1);
      apb(1'b0, 8'h04, 32'h0); chk("chen kept", rd, 32'h0);
      $display("test reset done");
      ce <= 1'b0;
      repeat (60) @(posedge clk);
      chk("ce freeze", {28'h0, stale}, 32'h0);
      ce <= 1'b1;
      $display("test clock enable done");
      apb(1'b1, 8'h00, 32'h0);
      repeat (60) @(posedge clk);
      chk("stale idle", {28'h0, stale}, 32'hF);
      selq.delete();
      apb(1'b1, 8'h04, 32'h4A);
      apb(1'b1, 8'h00, 32'h1);
      i = 0;
      while (selq.size() < 6 && i < 400) begin
         i++;
         @(posedge clk);
      end
      for (i = 0; i < 6; i++) chk("scan sel", {29'h0, selq[i]}, {29'h0, ord[i%3]});
      $display("test scan order done");
      apb(1'b1, 8'h00, 32'h0);
      repeat (30) @(posedge clk);
      delay <= 4'h9;
      codes[71:60] <= 12'h456;
      apb(1'b1, 8'h10, 32'h0000068D);
      apb(1'b1, 8'h0C, 32'h00000400);
      apb(1'b1, 8'h08, 32'h00000800);
      apb(1'b1, 8'h04, 32'h00000020);
      apb(1'b1, 8'h00, 32'h1);
      i = 0;
      @(posedge clk);
      while (upd[0] !== 1'b1 && i < 200) begin
         i++;
         @(posedge clk);
      end
      chk("mapped upd", {31'h0, upd[0]}, 32'h1);
      chk("mapped pos", {16'h0, pos[15:0]}, 32'h00000456);
      apb(1'b0, 8'h34, 32'h0); chk("feedback only result", rd, 32'h0);
      repeat (20) @(posedge clk);
      chk("stale mapped", {28'h0, stale}, 32'hE);
      $display("test mapping done");
      final_report;
   end
endmodule
